//--- smc_device.sv
// device end: serial control slave with its configuration registers
// assumes smc_pkg, and link pins arriving from the host's clock domain
`timescale 1ns/1ns
module smc_device (
	input wire logic clk, // system clock, 125 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire logic short_addr, // frames carry the 7-bit address
	output logic [12:0] pd_ctrl, // power-down control register
	output logic [1:0] dac_config, // converter configuration register
	output logic [7:0] wmm_config, // waveform memory configuration register
	smc_if.dev link // serial link to the host
);
	// ==========================================================
	// pin synchronisers
	logic [3:0] raw;
	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] filt;
	logic [3:0] filt_d;
	logic sclk_rise;
	logic sclk_fall;
	logic en_f;
	logic sdi_f;
	logic pin_reset;

	assign raw = {link.reset_n, link.sdi, link.en, link.sclk};

	// three stages; a level counts once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= smc_pkg::SYNC_RESET;
			s2 <= smc_pkg::SYNC_RESET;
			s3 <= smc_pkg::SYNC_RESET;
			filt <= smc_pkg::SYNC_RESET;
			filt_d <= smc_pkg::SYNC_RESET;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
			filt_d <= filt;
		end
	end

	// edges and levels of the filtered pins
	assign sclk_rise = filt[0] & ~filt_d[0];
	assign sclk_fall = ~filt[0] & filt_d[0];
	assign en_f = filt[1];
	assign sdi_f = filt[2];
	assign pin_reset = ~filt[3] & filt_d[3];

	// ==========================================================
	// frame engine
	smc_pkg::smc_dev_state_t state;
	logic [9:0] addr;
	logic [3:0] cnt;
	logic [3:0] alen;
	logic [3:0] width;
	logic [3:0] dcnt;
	logic [12:0] in_sh;
	logic [12:0] out_sh;
	logic [12:0] cur_value;
	logic [3:0] cur_width;
	logic commit;

	assign alen = short_addr ? smc_pkg::ADDR_SHORT : smc_pkg::ADDR_LONG;
	assign cur_width = smc_pkg::reg_width(short_addr, addr);

	// present value of the addressed register, right aligned
	always_comb begin
		cur_value = 13'h0000;
		if (cur_width == smc_pkg::PD_WIDTH)
			cur_value = pd_ctrl;
		else if (cur_width == smc_pkg::DAC_CFG_WIDTH)
			cur_value = {11'h000, dac_config};
		else if (cur_width == smc_pkg::WMM_WIDTH)
			cur_value = {5'h00, wmm_config};
	end

	// a write lands only when the whole register width came in
	assign commit = (state == smc_pkg::DEV_WRITE) && !en_f && (dcnt >= width);

	// frame sequencing, address and direction capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= smc_pkg::DEV_IDLE;
			addr <= 10'h000;
			cnt <= 4'h0;
			width <= 4'h0;
		end else if (pin_reset) begin
			state <= smc_pkg::DEV_IDLE;
		end else if (state != smc_pkg::DEV_IDLE && !en_f) begin
			state <= smc_pkg::DEV_IDLE;
		end else begin
			case (state)
				smc_pkg::DEV_IDLE: begin
					// first address bit rides on the start rise
					if (sclk_rise && en_f) begin
						addr <= {9'h000, sdi_f};
						cnt <= 4'h1;
						state <= smc_pkg::DEV_ADDR;
					end
				end
				smc_pkg::DEV_ADDR: begin
					if (sclk_rise) begin
						if (cnt < alen) begin
							addr <= {addr[8:0], sdi_f};
							cnt <= cnt + 4'h1;
						end else begin
							width <= cur_width;
							state <= (sdi_f == smc_pkg::DIR_WRITE) ? smc_pkg::DEV_WRITE
								: smc_pkg::DEV_READ;
						end
					end
				end
				smc_pkg::DEV_WRITE: begin
				end
				smc_pkg::DEV_READ: begin
				end
				default: begin
					state <= smc_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// incoming write data; only the last register-width bits count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_sh <= 13'h0000;
			dcnt <= 4'h0;
		end else if (state == smc_pkg::DEV_ADDR) begin
			in_sh <= 13'h0000;
			dcnt <= 4'h0;
		end else if (state == smc_pkg::DEV_WRITE && sclk_rise) begin
			in_sh <= {in_sh[11:0], sdi_f};
			if (dcnt != smc_pkg::REG_MAX)
				dcnt <= dcnt + 4'h1;
		end
	end

	// outgoing data: loaded at the direction bit, shifted on falls
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_sh <= 13'h0000;
			link.sdo <= 1'b0;
		end else if (pin_reset || !en_f) begin
			out_sh <= 13'h0000;
			link.sdo <= 1'b0;
		end else if (state == smc_pkg::DEV_ADDR && sclk_rise && cnt >= alen) begin
			out_sh <= cur_value << (smc_pkg::REG_MAX - cur_width);
		end else if ((state == smc_pkg::DEV_WRITE || state == smc_pkg::DEV_READ) && sclk_fall) begin
			link.sdo <= out_sh[12];
			out_sh <= {out_sh[11:0], 1'b0};
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pd_ctrl <= smc_pkg::PD_RESET;
			dac_config <= smc_pkg::DAC_CFG_RESET;
			wmm_config <= smc_pkg::WMM_CFG_RESET;
		end else if (pin_reset) begin
			pd_ctrl <= smc_pkg::PD_RESET;
			dac_config <= smc_pkg::DAC_CFG_RESET;
			wmm_config <= smc_pkg::WMM_CFG_RESET;
		end else if (commit) begin
			// each bit of pd_ctrl drives one block's power-down
			if (width == smc_pkg::PD_WIDTH)
				pd_ctrl <= in_sh;
			else if (width == smc_pkg::DAC_CFG_WIDTH)
				dac_config <= in_sh[1:0];
			else if (width == smc_pkg::WMM_WIDTH)
				wmm_config <= in_sh[7:0];
		end
	end
endmodule : smc_device

//--- smc_host.sv
// host end: drives frames on the serial link under Wishbone control
// assumes smc_pkg; software programs it over classic Wishbone
`timescale 1ns/1ns
module smc_host (
	input wire logic clk, // system clock, 125 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	smc_if.host link // serial link to the device
);
	// ==========================================================
	// registers
	logic [15:0] cmd;
	logic [15:0] wdata;
	logic [12:0] rx;
	logic hold_reset;
	logic start;
	logic done;
	logic busy;
	smc_pkg::smc_host_state_t state;

	// byte-lane merge for the low two lanes
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	assign busy = (state != smc_pkg::HOST_IDLE);

	// Wishbone slave: ack one cycle after the request, reads registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			cmd <= 16'h0000;
			wdata <= 16'h0000;
			hold_reset <= 1'b0;
			start <= 1'b0;
		end else begin
			wb_ack_o <= 1'b0;
			start <= 1'b0;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_ack_o <= 1'b1;
				wb_dat_o <= 32'h00000000;
				case (wb_adr_i[4:2])
					smc_pkg::HOST_CMD: wb_dat_o <= {16'h0000, cmd};
					smc_pkg::HOST_WDATA: wb_dat_o <= {16'h0000, wdata};
					smc_pkg::HOST_RDATA: wb_dat_o <= {19'h0, rx};
					smc_pkg::HOST_STATUS: wb_dat_o <= {30'h0, done, busy};
					smc_pkg::HOST_CTRL: wb_dat_o <= {31'h0, hold_reset};
					default: wb_dat_o <= 32'h00000000;
				endcase
				// command writes start a frame; ignored while busy
				if (wb_we_i && !busy) begin
					case (wb_adr_i[4:2])
						smc_pkg::HOST_CMD: begin
							cmd <= merge(cmd, wb_dat_i, wb_sel_i);
							start <= |wb_sel_i[1:0];
						end
						smc_pkg::HOST_WDATA: wdata <= merge(wdata, wb_dat_i, wb_sel_i);
						smc_pkg::HOST_CTRL: if (wb_sel_i[0]) hold_reset <= wb_dat_i[0];
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ==========================================================
	// return pin synchroniser
	logic sdo_s1;
	logic sdo_s2;
	logic sdo_s3;
	logic sdo_f;

	// three stages; a level counts once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdo_s1 <= 1'b0;
			sdo_s2 <= 1'b0;
			sdo_s3 <= 1'b0;
			sdo_f <= 1'b0;
		end else begin
			sdo_s1 <= link.sdo;
			sdo_s2 <= sdo_s1;
			sdo_s3 <= sdo_s2;
			if (sdo_s2 == sdo_s3)
				sdo_f <= sdo_s3;
		end
	end

	// ==========================================================
	// frame build
	logic [3:0] w;
	logic [3:0] alen;
	logic [4:0] nbits;
	logic [12:0] dfield;
	logic [23:0] tx_next;
	logic is_wr;
	logic fixed;

	assign is_wr = cmd[smc_pkg::CMD_WRITE_BIT];
	assign fixed = cmd[smc_pkg::CMD_FIXED_BIT] & is_wr;
	assign w = smc_pkg::reg_width(cmd[smc_pkg::CMD_SHORT_BIT], cmd[9:0]);
	assign alen = cmd[smc_pkg::CMD_SHORT_BIT] ? smc_pkg::ADDR_SHORT : smc_pkg::ADDR_LONG;
	assign nbits = 5'(alen) + 5'h01 + 5'(fixed ? smc_pkg::REG_MAX : w);

	// data left aligned, or zero padded at the front in fixed mode
	always_comb begin
		dfield = 13'h0000;
		if (fixed)
			dfield = wdata[12:0] & smc_pkg::low_mask(w);
		else if (is_wr)
			dfield = wdata[12:0] << (smc_pkg::REG_MAX - w);
		if (cmd[smc_pkg::CMD_SHORT_BIT])
			tx_next = {cmd[6:0], is_wr, dfield, 3'h0};
		else
			tx_next = {cmd[9:0], is_wr, dfield};
	end

	// ==========================================================
	// link engine: clock divider, shifting and frame ends
	logic [7:0] div;
	logic [4:0] left;
	logic [4:0] rcnt;
	logic [3:0] alen_r;
	logic [1:0] tail;
	logic [23:0] tx;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= smc_pkg::HOST_IDLE;
			link.sclk <= 1'b0;
			link.en <= 1'b0;
			link.sdi <= 1'b0;
			div <= 8'h00;
			left <= 5'h00;
			rcnt <= 5'h00;
			alen_r <= 4'h0;
			tail <= 2'h0;
			tx <= 24'h000000;
			rx <= 13'h0000;
			done <= 1'b0;
		end else if (state == smc_pkg::HOST_IDLE) begin
			link.sclk <= 1'b0;
			if (start) begin
				// frame opens with the clock low, first bit placed
				state <= smc_pkg::HOST_RUN;
				link.en <= 1'b1;
				link.sdi <= tx_next[23];
				tx <= {tx_next[22:0], 1'b0};
				left <= nbits - 5'h01;
				rcnt <= 5'h00;
				alen_r <= alen;
				div <= 8'h00;
				rx <= 13'h0000;
				done <= 1'b0;
			end
		end else if (div != smc_pkg::SCLK_HALF_M1) begin
			div <= div + 8'h01;
		end else begin
			div <= 8'h00;
			link.sclk <= ~link.sclk;
			if (!link.sclk) begin
				// rising edge: read data follows the direction bit
				if (state == smc_pkg::HOST_RUN && rcnt > 5'(alen_r))
					rx <= {rx[11:0], sdo_f};
				rcnt <= rcnt + 5'h01;
				if (state == smc_pkg::HOST_TAIL)
					tail <= tail + 2'h1;
			end else if (state == smc_pkg::HOST_RUN) begin
				// falling edge: next bit, or close the frame
				if (left != 5'h00) begin
					link.sdi <= tx[23];
					tx <= {tx[22:0], 1'b0};
					left <= left - 5'h01;
				end else begin
					link.en <= 1'b0;
					link.sdi <= 1'b0;
					tail <= 2'h0;
					state <= smc_pkg::HOST_TAIL;
				end
			end else if (tail == smc_pkg::TAIL_CLOCKS) begin
				state <= smc_pkg::HOST_IDLE;
				done <= 1'b1;
			end
		end
	end

	// device reset pin, driven low while software holds it
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			link.reset_n <= 1'b1;
		else
			link.reset_n <= ~hold_reset;
	end
endmodule : smc_host

//--- smc_if.sv
// four-wire serial control link plus the device reset pin
// assumes the bench instantiates it once and joins both ends to it
`timescale 1ns/1ns
interface smc_if;
	logic sclk; // serial clock, made by the host
	logic en; // frame select, high during a frame
	logic sdi; // host to device data
	logic sdo; // device to host data
	logic reset_n; // device reset pin, falling edge resets
	modport dev (
		input sclk,
		input en,
		input sdi,
		input reset_n,
		output sdo
	);
	modport host (
		output sclk,
		output en,
		output sdi,
		output reset_n,
		input sdo
	);
endinterface : smc_if

//--- smc_monitor.sv
// link checker: timing and framing of the serial control wires
// assumes tb_top instantiates it beside the interface that joins both ends
`timescale 1ns/1ns
module smc_monitor (
	input wire logic clk, // system clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic sclk, // serial clock
	input wire logic en, // frame select
	input wire logic sdi, // host to device data
	input wire logic sdo, // device to host data
	input wire logic reset_n // device reset pin
);
	// every property runs on the system clock and sleeps in reset
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// idle time
	logic [7:0] idle_cnt;
	// cycles since frame select went low, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			idle_cnt <= 8'hff;
		else if (en)
			idle_cnt <= 8'h00;
		else if (idle_cnt != 8'hff)
			idle_cnt <= idle_cnt + 8'h01;
	end
	// ==========================================================
	// assertions
	a_start_clock_low: assert property ($rose(en) |-> !sclk)
		else $error("frame select rose with serial clock high");
	a_first_rise_on_time: assert property ($rose(en) |-> ##16 $rose(sclk))
		else $error("first serial clock rise not one half period after start");
	a_end_on_fall: assert property ($fell(en) |-> $fell(sclk))
		else $error("frame select fell away from a serial clock fall");
	a_sdi_moves_low: assert property ($changed(sdi) |-> !sclk)
		else $error("host data changed while serial clock high");
	a_half_period: assert property ($rose(sclk) |-> ##16 $fell(sclk))
		else $error("serial clock high time wrong");
	a_tail_clocks: assert property ($fell(en) |-> ##16 sclk ##32 sclk ##32 sclk ##16 !sclk)
		else $error("three trailing clocks missing after frame end");
	a_sdo_moves_low: assert property ($changed(sdo) |-> !sclk)
		else $error("device data changed while serial clock high");
	a_idle_quiet: assert property (idle_cnt >= 8'h80 |-> !sclk && !sdo)
		else $error("link not quiet between frames");
	// ==========================================================
	// coverage of main scenarios
	c_frame_end: cover property ($fell(en));
	c_pin_reset: cover property ($fell(reset_n));
	c_read_data: cover property (en && $rose(sdo));
endmodule : smc_monitor

//--- smc_pkg.sv
// constants, register map and shared decoding for the serial control port
// assumes both ends and the bench compile this package first
package smc_pkg;
	// ==========================================================
	// clock and link timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_HALF_NS = 128;
	localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SCLK_HALF_M1 = 8'(SCLK_HALF_CYCLES - 1);
	localparam logic [1:0] TAIL_CLOCKS = 2'h3;
	// ==========================================================
	// frame layout
	localparam logic [3:0] ADDR_LONG = 4'ha;
	localparam logic [3:0] ADDR_SHORT = 4'h7;
	localparam logic [3:0] REG_MAX = 4'hd;
	localparam logic DIR_READ = 1'b0;
	localparam logic DIR_WRITE = 1'b1;
	localparam logic [3:0] SYNC_RESET = 4'h8; // reset pin idles high
	// ==========================================================
	// register map
	localparam logic [9:0] PD_ADDR = 10'h1c3;
	localparam logic [3:0] PD_WIDTH = 4'hd;
	localparam logic [12:0] PD_RESET = 13'h1fc0;
	localparam logic [9:0] DAC_CFG_ADDR = 10'h1c0;
	localparam logic [3:0] DAC_CFG_WIDTH = 4'h2;
	localparam logic [1:0] DAC_CFG_RESET = 2'h0;
	localparam logic [6:0] WMM_CFG_ADDR = 7'h00;
	localparam logic [3:0] WMM_WIDTH = 4'h8;
	localparam logic [7:0] WMM_CFG_RESET = 8'h00;
	// power-down control bit positions
	localparam int LOW_REGULATOR_OFF_BIT = 0;
	localparam int CLOCK_REGULATOR_OFF_BIT = 1;
	localparam int CONVERTER_REGULATOR_OFF_BIT = 2;
	localparam int BANDGAP_REGULATOR_OFF_BIT = 3;
	localparam int SHARED_CLOCKS_OFF_BIT = 4;
	localparam int OUT_CLOCKS_OFF_BIT = 5;
	localparam int LOOP_CLOCKS_OFF_BIT = 6;
	localparam int TEST_B_OFF_BIT = 7;
	localparam int TEST_A_OFF_BIT = 8;
	localparam int INPUT_B_OFF_BIT = 9;
	localparam int INPUT_A_OFF_BIT = 10;
	localparam int CORE_B_OFF_BIT = 11;
	localparam int CORE_A_OFF_BIT = 12;
	// recommended settings with output and loop clocks on
	localparam logic [12:0] PD_ONLY_A = 13'h0b80;
	localparam logic [12:0] PD_ONLY_B = 13'h1580;
	localparam logic [12:0] PD_BOTH = 13'h0180;
	// ==========================================================
	// host register offsets and fields
	localparam logic [2:0] HOST_CMD = 3'h0;
	localparam logic [2:0] HOST_WDATA = 3'h1;
	localparam logic [2:0] HOST_RDATA = 3'h2;
	localparam logic [2:0] HOST_STATUS = 3'h3;
	localparam logic [2:0] HOST_CTRL = 3'h4;
	localparam int CMD_WRITE_BIT = 10;
	localparam int CMD_SHORT_BIT = 11;
	localparam int CMD_FIXED_BIT = 12;
	// ==========================================================
	// states
	typedef enum logic [1:0] {
		DEV_IDLE = 2'h0,
		DEV_ADDR = 2'h1,
		DEV_WRITE = 2'h3,
		DEV_READ = 2'h2
	} smc_dev_state_t;
	typedef enum logic [1:0] {
		HOST_IDLE = 2'h0,
		HOST_RUN = 2'h1,
		HOST_TAIL = 2'h3
	} smc_host_state_t;
	// ==========================================================
	// width of the addressed register, zero when unmapped
	function automatic logic [3:0] reg_width(input logic short_a, input logic [9:0] a);
		logic [3:0] w;
		w = 4'h0;
		if (short_a) begin
			if (a[6:0] == WMM_CFG_ADDR)
				w = WMM_WIDTH;
		end else if (a == PD_ADDR) begin
			w = PD_WIDTH;
		end else if (a == DAC_CFG_ADDR) begin
			w = DAC_CFG_WIDTH;
		end
		return w;
	endfunction : reg_width
	// ones in the low w bits
	function automatic logic [12:0] low_mask(input logic [3:0] w);
		return ~(13'h1fff << w);
	endfunction : low_mask
endpackage : smc_pkg

//--- tb_top.sv
// bench: both ends joined by the link, host driven over classic Wishbone
// assumes smc_pkg, smc_if, smc_device, smc_host and smc_monitor compiled first
`timescale 1ns/1ns
module tb_top;
	logic clk, rst, short_addr, cyc, stb, we, wb_ack_o;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, wb_dat_o, got;
	logic [12:0] pd_ctrl, prev;
	logic [1:0] dac_config;
	logic [7:0] wmm_config;
	logic [12:0] vals [3] = '{smc_pkg::PD_ONLY_A, smc_pkg::PD_ONLY_B, smc_pkg::PD_BOTH};
	logic [1:0] cfgs [3] = '{2'h2, 2'h1, 2'h0}; // converter config matching each power-down value
	int n_errors = 0;
	int samples_checked = 0;
	int k;
	// ==========================================================
	// the two ends, the link and its checker
	smc_if sl ();
	smc_device smc_device_i (.clk(clk), .rst(rst), .short_addr(short_addr), .pd_ctrl(pd_ctrl),
		.dac_config(dac_config), .wmm_config(wmm_config), .link(sl));
	smc_host smc_host_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.link(sl));
	smc_monitor smc_monitor_i (.clk(clk), .rst(rst), .sclk(sl.sclk), .en(sl.en), .sdi(sl.sdi),
		.sdo(sl.sdo), .reset_n(sl.reset_n));
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ==========================================================
	// tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got %h want %h", $time, g, e);
		end
	endtask : check
	// one classic Wishbone cycle, read data lands in got
	task automatic wb(input logic w, input logic [2:0] r, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {3'h0, r, 2'h0};
		wdat <= d;
		n = 0;
		// ack and read data are taken at the rising edge that sees ack high
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			n_errors++;
			final_report();
		end else begin
			got = wb_dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask : wb
	// one serial frame: cmd is {fixed, short, write, address}
	task automatic frame(input logic [12:0] c, input logic [12:0] d);
		int n;
		wb(1'b1, smc_pkg::HOST_WDATA, 32'(d));
		wb(1'b1, smc_pkg::HOST_CMD, 32'(c));
		n = 0;
		do begin
			wb(1'b0, smc_pkg::HOST_STATUS, 32'h0);
			n++;
		end while (got[1:0] !== 2'b10 && n < 600);
		if (got[1:0] !== 2'b10) begin
			n_errors++;
			final_report();
		end
	endtask : frame
	// ==========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		short_addr = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		sel = 4'h3;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(32'(pd_ctrl), 32'(smc_pkg::PD_RESET));
		check(32'(dac_config), 32'h0);
		check(32'(wmm_config), 32'h0);
		$display("test defaults done");
		// write, previous contents out, read back, converter config kept in step
		prev = smc_pkg::PD_RESET;
		for (k = 0; k < 3; k++) begin
			frame({3'b001, smc_pkg::PD_ADDR}, vals[k]);
			check(32'(pd_ctrl), 32'(vals[k]));
			wb(1'b0, smc_pkg::HOST_RDATA, 32'h0);
			check(got, 32'(prev));
			frame({3'b000, smc_pkg::PD_ADDR}, 13'h0000);
			wb(1'b0, smc_pkg::HOST_RDATA, 32'h0);
			check(got, 32'(vals[k]));
			frame({3'b001, smc_pkg::DAC_CFG_ADDR}, 13'(cfgs[k]));
			check(32'(dac_config), 32'(cfgs[k]));
			prev = vals[k];
		end
		$display("test power-down writes done");
		// fixed 13-bit packets into the 2-bit register; old value then zeros return
		frame({3'b101, smc_pkg::DAC_CFG_ADDR}, 13'h0002);
		check(32'(dac_config), 32'h2);
		frame({3'b101, smc_pkg::DAC_CFG_ADDR}, 13'h0001);
		check(32'(dac_config), 32'h1);
		wb(1'b0, smc_pkg::HOST_RDATA, 32'h0);
		check(got, 32'h1000);
		$display("test padded write done");
		// short address bank, eight-bit read back
		short_addr <= 1'b1;
		frame({3'b011, 3'h0, smc_pkg::WMM_CFG_ADDR}, 13'h00a5);
		check(32'(wmm_config), 32'ha5);
		frame({3'b010, 3'h0, smc_pkg::WMM_CFG_ADDR}, 13'h0000);
		wb(1'b0, smc_pkg::HOST_RDATA, 32'h0);
		check(got, 32'ha5);
		// long frame seen by the short bank: write bit lands, only three data bits follow
		frame({3'b001, 10'h004}, 13'h0000);
		check(32'(wmm_config), 32'ha5);
		short_addr <= 1'b0;
		$display("test short address done");
		// unmapped link address and host offset
		frame({3'b001, 10'h155}, 13'h1fff);
		check(32'(pd_ctrl), 32'(smc_pkg::PD_BOTH));
		wb(1'b0, 3'h7, 32'h0);
		check(got, 32'h0);
		$display("test unmapped done");
		// device reset pin restores defaults
		wb(1'b1, smc_pkg::HOST_CTRL, 32'h1);
		k = 0;
		while (pd_ctrl !== smc_pkg::PD_RESET && k < 40) begin
			@(negedge clk);
			k++;
		end
		wb(1'b1, smc_pkg::HOST_CTRL, 32'h0);
		check(32'(pd_ctrl), 32'(smc_pkg::PD_RESET));
		check(32'(dac_config), 32'h0);
		check(32'(wmm_config), 32'h0);
		$display("test reset pin done");
		final_report();
	end
endmodule : tb_top
